/* File: rtl/opmd_defines.vh */
`ifndef OPMD_DEFINES_VH
`define OPMD_DEFINES_VH

// register indices on the 3-bit register port
`define OPMD_ADDR_DATA 3'h0
`define OPMD_ADDR_CMD 3'h1
`define OPMD_ADDR_MODE 3'h2
`define OPMD_ADDR_PVAL 3'h3
`define OPMD_ADDR_PMASK 3'h4
`define OPMD_ADDR_DESKEW 3'h5

// mode register fields
`define OPMD_MODE_EN 0
`define OPMD_MODE_SB 1
`define OPMD_MODE_ITB 2
`define OPMD_MODE_IMO 3
`define OPMD_MODE_DTE 4
`define OPMD_MODE_PMS_LO 5
`define OPMD_MODE_PMS_HI 6
`define OPMD_MODE_WMASK 8'h7f

// match_mode_select codes
`define OPMD_PMS_OFF 2'h0
`define OPMD_PMS_AND 2'h1
`define OPMD_PMS_OR 2'h2
`define OPMD_PMS_EVT 2'h3

// command/status register fields
`define OPMD_CMD_CLR_IP 0
`define OPMD_ST_IP 0
`define OPMD_ST_ORE 1
`define OPMD_ST_PMF 2
`define OPMD_ST_BUF 3
`define OPMD_ST_DAV 4
`define OPMD_ST_HELD 5

// reset values
`define OPMD_MODE_RST 8'h00
`define OPMD_PVAL_RST 8'h00
`define OPMD_PMASK_RST 8'h00
`define OPMD_DESKEW_RST 4'h0
`define OPMD_ACK_RST 1'b1

// deskew timer width; field value n gives n+1 cycles, 16 at most
`define OPMD_DESKEW_W 4

`endif

/* File: rtl/opmd_sync.v */
`timescale 1ns/10ps
`default_nettype none
`include "opmd_defines.vh"

module opmd_sync (
  // clock and reset
  input wire mclk,
  input wire resetn,
  // asynchronous level in, synchronised level out
  input wire async_in,
  output reg sync_out_q
);

  reg meta_q;

  // meta_q feeds only the second stage
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= `OPMD_ACK_RST;
      sync_out_q <= `OPMD_ACK_RST;
    end else begin
      meta_q <= async_in;
      sync_out_q <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/opmd_deskew.v */
`timescale 1ns/10ps
`default_nettype none
`include "opmd_defines.vh"

module opmd_deskew (
  // clock and reset
  input wire mclk,
  input wire resetn,
  // control
  input wire start,
  input wire [`OPMD_DESKEW_W-1:0] count,
  // status
  output reg done_q
);

  reg [`OPMD_DESKEW_W-1:0] cnt_q;

  // done rises count+1 cycles after the start cycle
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= {`OPMD_DESKEW_W{1'b0}};
      done_q <= 1'b1;
    end else if (start) begin
      cnt_q <= count;
      done_q <= 1'b0;
    end else if (!done_q) begin
      if (cnt_q == {`OPMD_DESKEW_W{1'b0}}) begin
        done_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q - {{(`OPMD_DESKEW_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

/* File: rtl/opmd_output_port.v */
// Overview of operation
// - output matching offers only AND and OR
// - match flag updates on each buffer load
// - one-byte mode: load sets irq pending unless single-buffered, where the drain sets it
// - flag set: only command or disable clears irq pending
// - flag set: fill needs write and clear
// - early write still latched, not yet filled
// - two-byte mode: matching load sets pending
// - second byte match sets pending and flag
// - match-only: request only on matching load
// - port owns a 4-bit deskew timer
// - enabled deskew delays data-available after load
// - deskew delays available past ack rising until the timer ends
// - write into empty buffer moves data out
// - new data write clears register-empty flag
// - ack falling empties buffer, available rises
// - emptied buffer takes next pending byte
// - available stays high while ack low
// - available falls only once ack is high
// - two-byte mode: pending when both empty
// - data-available is active low
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "opmd_defines.vh"

module opmd_output_port (
  // clock and reset
  input wire mclk,
  input wire resetn,
  // register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  // handshake pins
  output reg [7:0] port_data_q,
  output reg data_avail_n_q,
  input wire ack_input_n,
  // interrupt request level
  output reg irq_request_q
);

  // handshake states
  localparam [3:0] ST_EMPTY = 4'b0001;
  localparam [3:0] ST_SKEW = 4'b0010;
  localparam [3:0] ST_HOLD = 4'b0100;
  localparam [3:0] ST_AVAIL = 4'b1000;

  // software registers
  reg [7:0] mode_q;
  reg [7:0] pat_val_q;
  reg [7:0] pat_mask_q;
  reg [`OPMD_DESKEW_W-1:0] deskew_cnt_q;

  // data path state
  reg [7:0] odr_q;
  reg odr_full_q;
  reg held_q;
  reg irq_pending_q;
  reg match_flag_q;
  reg ack_prev_q;
  reg [3:0] state_q;
  reg [3:0] state_d;

  // combinational terms
  reg byte_match;
  reg odr_full_d;
  reg held_d;
  reg irq_pending_d;
  wire ack_s;
  wire desk_done;

  // decoded mode bits
  wire port_en = mode_q[`OPMD_MODE_EN];
  wire single_buffer_mode = mode_q[`OPMD_MODE_SB];
  wire two_byte_irq_mode = mode_q[`OPMD_MODE_ITB];
  wire irq_on_match_only = mode_q[`OPMD_MODE_IMO];
  wire deskew_enable = mode_q[`OPMD_MODE_DTE];
  wire [1:0] match_mode_select =
    mode_q[`OPMD_MODE_PMS_HI:`OPMD_MODE_PMS_LO];

  // register port decode
  wire wr_data = reg_wr & (reg_addr == `OPMD_ADDR_DATA);
  wire wr_cmd = reg_wr & (reg_addr == `OPMD_ADDR_CMD);
  wire wr_mode = reg_wr & (reg_addr == `OPMD_ADDR_MODE);
  wire wr_pval = reg_wr & (reg_addr == `OPMD_ADDR_PVAL);
  wire wr_pmask = reg_wr & (reg_addr == `OPMD_ADDR_PMASK);
  wire wr_deskew = reg_wr & (reg_addr == `OPMD_ADDR_DESKEW);
  wire clr_ip_cmd = wr_cmd & reg_wdata[`OPMD_CMD_CLR_IP];

  // status derived from state
  wire buf_full = ~state_q[0];
  wire out_reg_empty = ~odr_full_q;

  // acknowledge pin passes two flip-flops first
  opmd_sync u_ack_sync (
    .mclk(mclk),
    .resetn(resetn),
    .async_in(ack_input_n),
    .sync_out_q(ack_s)
  );

  // receiver has taken the byte
  wire ack_fall = ack_prev_q & ~ack_s;

  // buffer load: output register full, buffer empty
  wire move = port_en & odr_full_q & ~buf_full;

  // buffer emptied by the receiver
  wire drain = port_en & state_q[3] & ack_fall;

  // pattern test on the byte being moved
  wire [7:0] bit_hit = ~(odr_q ^ pat_val_q) & pat_mask_q;

  always @* begin
    case (match_mode_select)
      `OPMD_PMS_AND: byte_match = (bit_hit == pat_mask_q);
      `OPMD_PMS_OR: byte_match = |bit_hit;
      // transition mode needs history; never matches here
      `OPMD_PMS_EVT: byte_match = 1'b0;
      default: byte_match = 1'b0;
    endcase
  end

  // pending set on a load
  wire set_on_move = move & (irq_on_match_only ? byte_match :
    (byte_match |
     (~two_byte_irq_mode & ~single_buffer_mode)));

  // pending set on a drain
  wire set_on_drain = drain & ~irq_on_match_only &
    ((single_buffer_mode) |
     (two_byte_irq_mode & ~odr_full_q & ~held_q));

  // data write that clears pending, only when no match is flagged
  wire write_clears = wr_data & port_en & ~match_flag_q &
    (~two_byte_irq_mode | buf_full);

  // deskew timer, started by every buffer load
  opmd_deskew u_deskew (
    .mclk(mclk),
    .resetn(resetn),
    .start(move),
    .count(deskew_cnt_q),
    .done_q(desk_done)
  );

  // software registers
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= `OPMD_MODE_RST;
      pat_val_q <= `OPMD_PVAL_RST;
      pat_mask_q <= `OPMD_PMASK_RST;
      deskew_cnt_q <= `OPMD_DESKEW_RST;
    end else begin
      if (wr_mode) begin
        mode_q <= reg_wdata & `OPMD_MODE_WMASK;
      end
      if (wr_pval) begin
        pat_val_q <= reg_wdata;
      end
      if (wr_pmask) begin
        pat_mask_q <= reg_wdata;
      end
      if (wr_deskew) begin
        deskew_cnt_q <= reg_wdata[`OPMD_DESKEW_W-1:0];
      end
    end
  end

  // output data register contents
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      odr_q <= 8'h00;
    end else if (wr_data) begin
      odr_q <= reg_wdata;
    end
  end

  // output data register fill state
  always @* begin
    odr_full_d = odr_full_q;
    held_d = held_q;
    if (move & ~single_buffer_mode) begin
      odr_full_d = 1'b0;
    end
    if (drain & single_buffer_mode) begin
      odr_full_d = 1'b0;
    end
    if (held_q & ~irq_pending_q) begin
      odr_full_d = 1'b1;
      held_d = 1'b0;
    end
    if (wr_data & port_en) begin
      if (match_flag_q) begin
        held_d = 1'b1;
      end else begin
        odr_full_d = 1'b1;
      end
    end
    if (!port_en) begin
      odr_full_d = 1'b0;
      held_d = 1'b0;
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      odr_full_q <= 1'b0;
      held_q <= 1'b0;
    end else begin
      odr_full_q <= odr_full_d;
      held_q <= held_d;
    end
  end

  // interrupt pending: a set wins over command and write clears; disable clears over all
  always @* begin
    irq_pending_d = irq_pending_q;
    if (clr_ip_cmd | write_clears) begin
      irq_pending_d = 1'b0;
    end
    if (set_on_move | set_on_drain) begin
      irq_pending_d = 1'b1;
    end
    if (!port_en) begin
      irq_pending_d = 1'b0;
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_pending_q <= 1'b0;
    end else begin
      irq_pending_q <= irq_pending_d;
    end
  end

  // match flag follows the byte moved into the buffer
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      match_flag_q <= 1'b0;
    end else if (!port_en) begin
      match_flag_q <= 1'b0;
    end else if (move) begin
      match_flag_q <= byte_match;
    end
  end

  // buffer register drives the pins
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      port_data_q <= 8'h00;
    end else if (move) begin
      port_data_q <= odr_q;
    end
  end

  // previous synchronised acknowledge for edge detection
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ack_prev_q <= `OPMD_ACK_RST;
    end else begin
      ack_prev_q <= ack_s;
    end
  end

  // interlocked handshake
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_EMPTY: begin
        if (move) begin
          if (deskew_enable) begin
            state_d = ST_SKEW;
          end else if (ack_s) begin
            state_d = ST_AVAIL;
          end else begin
            state_d = ST_HOLD;
          end
        end
      end
      ST_SKEW: begin
        // timer runs from the load, not from ack rising
        if (desk_done) begin
          if (ack_s) begin
            state_d = ST_AVAIL;
          end else begin
            state_d = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        if (ack_s) begin
          state_d = ST_AVAIL;
        end
      end
      ST_AVAIL: begin
        if (ack_fall) begin
          state_d = ST_EMPTY;
        end
      end
      default: begin
        state_d = ST_EMPTY;
      end
    endcase
    if (!port_en) begin
      state_d = ST_EMPTY;
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_EMPTY;
    end else begin
      state_q <= state_d;
    end
  end

  // data-available low only in the available state
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      data_avail_n_q <= 1'b1;
    end else begin
      data_avail_n_q <= ~(state_d == ST_AVAIL);
    end
  end

  // interrupt request level toward the system
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_request_q <= 1'b0;
    end else begin
      irq_request_q <= irq_pending_d & port_en;
    end
  end

  // read data valid in the cycle after the read strobe only
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `OPMD_ADDR_DATA: reg_rdata_q <= port_data_q;
        `OPMD_ADDR_CMD: begin
          reg_rdata_q <= {2'h0,
            held_q,
            ~data_avail_n_q,
            buf_full,
            match_flag_q,
            out_reg_empty,
            irq_pending_q};
        end
        `OPMD_ADDR_MODE: reg_rdata_q <= mode_q;
        `OPMD_ADDR_PVAL: reg_rdata_q <= pat_val_q;
        `OPMD_ADDR_PMASK: reg_rdata_q <= pat_mask_q;
        `OPMD_ADDR_DESKEW: begin
          reg_rdata_q <= {4'h0, deskew_cnt_q};
        end
        default: reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

endmodule

`default_nettype wire

/* File: verification/opmd_output_port_props.sv */
`timescale 1ns/10ps
`default_nettype none

module opmd_output_port_props (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  // handshake pins and request
  input wire logic [7:0] port_data_q,
  input wire logic data_avail_n_q,
  input wire logic ack_input_n,
  input wire logic irq_request_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_fall_needs_ack: assert property ($fell(data_avail_n_q) |-> $past(ack_input_n, 3))
    else $error("data available fell while acknowledge was low");
  chk_low_ack_blocks: assert property (data_avail_n_q && !ack_input_n |=> data_avail_n_q)
    else $error("data available fell during low acknowledge");
  chk_ack_empties: assert property ($fell(ack_input_n) && !data_avail_n_q |-> ##[1:6] data_avail_n_q)
    else $error("data available did not rise after acknowledge fell");
  chk_avail_holds: assert property (!data_avail_n_q && ack_input_n |=> !data_avail_n_q)
    else $error("data available rose without acknowledge");
  chk_load_when_empty: assert property ($changed(port_data_q) |-> $past(data_avail_n_q))
    else $error("pins changed while buffer was full");
  chk_data_stable: assert property (!data_avail_n_q && $past(!data_avail_n_q) |-> $stable(port_data_q))
    else $error("pins changed while data available");
  chk_reset_idle: assert property ($rose(resetn) |-> data_avail_n_q && !irq_request_q)
    else $error("outputs not idle after reset");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
    else $error("read data present without read");
endmodule

bind opmd_output_port opmd_output_port_props u_props (
  .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .port_data_q(port_data_q),
  .data_avail_n_q(data_avail_n_q), .ack_input_n(ack_input_n), .irq_request_q(irq_request_q)
);

`default_nettype wire

/* File: verification/opmd_rcv_model.sv */
`timescale 1ns/10ps
`default_nettype none

module opmd_rcv_model (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // handshake
  input wire logic data_avail_n,
  input wire logic [7:0] port_data,
  output var logic ack_input_n,
  // control and record
  input wire logic go,
  output var logic [7:0] last_byte,
  output var logic [7:0] taken
);
  logic [1:0] wait_q;

  // ack differs from data_avail only while a step of the handshake is owed
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ack_input_n <= 1'b1;
      wait_q <= 2'h0;
      last_byte <= 8'h00;
      taken <= 8'h00;
    end else if (!go || (ack_input_n == data_avail_n)) begin
      wait_q <= 2'h0;
    end else if (wait_q != 2'h3) begin
      wait_q <= wait_q + 2'h1;
    end else begin
      wait_q <= 2'h0;
      ack_input_n <= !ack_input_n;
      if (ack_input_n) begin
        last_byte <= port_data;
        taken <= taken + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "opmd_defines.vh"

module tb_top;
  localparam logic [2:0] DA = `OPMD_ADDR_DATA;
  localparam logic [2:0] ST = `OPMD_ADDR_CMD;
  localparam logic [2:0] MD = `OPMD_ADDR_MODE;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic go = 1'b0;
  wire [7:0] reg_rdata_q;
  wire [7:0] port_data_q;
  wire [7:0] last_byte;
  wire [7:0] taken;
  wire data_avail_n_q;
  wire ack_input_n;
  wire irq_request_q;
  int errors = 0;
  int checks_done = 0;
  int n;

  always #2 mclk = ~mclk;

  opmd_output_port u_dut (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .port_data_q(port_data_q),
    .data_avail_n_q(data_avail_n_q), .ack_input_n(ack_input_n), .irq_request_q(irq_request_q)
  );
  opmd_rcv_model u_rcv (
    .mclk(mclk), .resetn(resetn), .data_avail_n(data_avail_n_q), .port_data(port_data_q),
    .ack_input_n(ack_input_n), .go(go), .last_byte(last_byte), .taken(taken)
  );

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_q, exp);
  endtask

  // let the receiver run until it has taken the given count, then freeze it idle
  task automatic drain(input logic [7:0] target);
    @(posedge mclk);
    go <= 1'b1;
    n = 0;
    while (taken !== target && n < 300) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 300) begin
      errors++;
      end_of_test();
    end
    repeat (16) @(posedge mclk);
    go <= 1'b0;
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    chk({7'h00, data_avail_n_q}, 8'h01);
    rd(ST, 8'h02);
    rd(3'h6, 8'h00);
    $display("reset test end");
    wr(MD, 8'h01);
    wr(DA, 8'h5a);
    repeat (3) @(posedge mclk);
    #1;
    chk(port_data_q, 8'h5a);
    chk({7'h00, irq_request_q}, 8'h01);
    rd(ST, 8'h1b);
    wr(DA, 8'ha5);
    rd(ST, 8'h18);
    drain(8'h02);
    chk(last_byte, 8'ha5);
    rd(ST, 8'h03);
    $display("handshake test end");
    wr(`OPMD_ADDR_DESKEW, 8'h05);
    wr(MD, 8'h11);
    wr(DA, 8'h33);
    n = 0;
    while (data_avail_n_q !== 1'b0 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 40) begin
      errors++;
      end_of_test();
    end
    chk({7'h00, n >= 8 && n < 40}, 8'h01);
    drain(8'h03);
    $display("deskew test end");
    wr(`OPMD_ADDR_PVAL, 8'h3c);
    wr(`OPMD_ADDR_PMASK, 8'hff);
    wr(MD, 8'h21);
    wr(ST, 8'h01);
    wr(DA, 8'h3c);
    rd(ST, 8'h1f);
    wr(DA, 8'h11);
    rd(ST, 8'h3f);
    wr(ST, 8'h01);
    rd(ST, 8'h1c);
    drain(8'h05);
    chk(last_byte, 8'h11);
    rd(ST, 8'h03);
    $display("match hold test end");
    for (int m = 1; m < 4; m++) begin
      wr(MD, {1'b0, m[1:0], 5'h09});
      wr(ST, 8'h01);
      wr(DA, 8'hc3);
      drain(taken + 8'h01);
      rd(ST, 8'h02);
      wr(DA, 8'h3c);
      drain(taken + 8'h01);
      rd(ST, (m == 3) ? 8'h02 : 8'h07);
      chk({7'h00, irq_request_q}, (m == 3) ? 8'h00 : 8'h01);
    end
    $display("match only test end");
    wr(MD, 8'h05);
    wr(DA, 8'h01);
    rd(ST, 8'h1a);
    wr(DA, 8'h02);
    drain(taken + 8'h02);
    rd(ST, 8'h03);
    wr(MD, 8'h25);
    wr(ST, 8'h01);
    wr(DA, 8'h3c);
    rd(ST, 8'h1f);
    drain(taken + 8'h01);
    $display("two byte test end");
    end_of_test();
  end
endmodule

`default_nettype wire
